// >>> dmr_pkg.sv
// Shared constants, types and functions for the mode register six block.
// Assumes both ends import it and use one common clock.
package dmr_pkg;

   // ***************************************************************
   // Mode register word layout
   // ***************************************************************
   localparam int MR_W = 22;
   localparam int SEL_LSB = 18;
   localparam logic [2:0] SEL_MR5 = 3'h5;
   localparam logic [2:0] SEL_MR6 = 3'h6;
   localparam int RSV21_BIT = 21;
   localparam int RSV17_BIT = 17;
   localparam int RSV13_BIT = 13;
   localparam int RSV9_BIT = 9;
   localparam int RSV8_BIT = 8;
   // Fifth mode register fields
   localparam int MR5_LAT_LSB = 0;
   localparam int MR5_CRC_BIT = 3;
   localparam int MR5_PAR_BIT = 4;
   localparam int MR5_PERSIST_BIT = 9;
   localparam logic [2:0] LAT_OFF = 3'h0;
   localparam logic [2:0] LAT_MAX = 3'h3;
   // Sixth mode register fields
   localparam int MR6_VAL_LSB = 0;
   localparam int MR6_RANGE_BIT = 6;
   localparam int MR6_CAL_EN_BIT = 7;
   localparam int MR6_RATE_LSB = 10;
   localparam logic [2:0] RATE_TOP = 3'h4;
   localparam logic [5:0] VREF_LAST = 6'h31;
   localparam logic [MR_W-1:0] MR6_RESET = 22'h000000;

   // ***************************************************************
   // Controller register offsets
   // ***************************************************************
   localparam logic [3:0] REG_MRS_OP = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STEP = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;

   // Command and address pins covered by parity
   typedef struct packed {
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic a17;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [13:0] addr;
   } dmr_ca_t;

   localparam dmr_ca_t CA_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                   2'h0, 2'h0, 14'h0000};

   // Even parity over every covered pin
   function automatic logic dmr_ca_parity(input dmr_ca_t ca);
      dmr_ca_parity = ^ca;
   endfunction : dmr_ca_parity

   // Mode register word carried by the pins of a set command
   function automatic logic [MR_W-1:0] dmr_op_of(input dmr_ca_t ca);
      dmr_op_of = {ca.bg, ca.ba, ca.a17, 3'h0, ca.addr};
   endfunction : dmr_op_of

endpackage : dmr_pkg

// >>> dmr_if.sv
// Command bus between memory controller and device.
// Assumes one clock shared by both ends; no two-way pins.
`timescale 1ns/10ps
interface dmr_if;
   import dmr_pkg::*;
   logic cke;
   logic cs_n;
   logic odt;
   logic par;
   dmr_ca_t ca;

   modport dev (input cke, input cs_n, input odt, input par, input ca);
   modport ctl (output cke, output cs_n, output odt, output par,
                output ca);
endinterface : dmr_if

// >>> dmr_device.sv
// Device end: mode register six, parity check and error status flags.
// Assumes commands are sampled on the rising clock edge, synchronous.
// Every output comes straight from one packed state register.
`timescale 1ns/10ps
module dmr_device (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   dmr_if.dev bus,
   input wire logic write_crc_error,
   output logic cmd_exec,
   output dmr_pkg::dmr_ca_t cmd_pins,
   output logic parity_error_pulse,
   output logic parity_error_flag,
   output logic crc_error_flag,
   output logic parity_check_on,
   output logic [2:0] parity_latency,
   output logic persistent_mode,
   output logic [2:0] data_rate,
   output logic data_rate_reserved,
   output logic vref_cal_en,
   output logic vref_range,
   output logic [5:0] vref_value,
   output logic vref_value_bad,
   output logic vref_monitor_en
);
   import dmr_pkg::*;

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   // Checking runs for a valid latency code and, once an error has
   // been flagged, only in persistent mode; reserved codes count as off
   function automatic logic check_live(input logic [2:0] lat,
                                       input logic err,
                                       input logic pers);
      check_live = (lat != LAT_OFF) && (lat <= LAT_MAX)
                   && (!err || pers);
   endfunction : check_live

   // Register select field of a mode word
   function automatic logic [2:0] sel_of(input logic [MR_W-1:0] w);
      sel_of = w[SEL_LSB +: 3];
   endfunction : sel_of

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [2:0] par_lat;
      logic persist;
      logic par_err;
      logic crc_err;
      logic [2:0] rate;
      logic cal_en;
      logic range;
      logic [5:0] value;
      logic exec;
      dmr_ca_t pins;
      logic par_pulse;
      logic rate_rsvd;
      logic value_bad;
      logic check_on;
      logic mon_en;
   } dmr_dev_st_t;

   localparam dmr_dev_st_t ST_RESET = '{
      par_lat: LAT_OFF,
      rate: MR6_RESET[MR6_RATE_LSB +: 3],
      cal_en: MR6_RESET[MR6_CAL_EN_BIT],
      range: MR6_RESET[MR6_RANGE_BIT],
      value: MR6_RESET[MR6_VAL_LSB +: 6],
      pins: CA_IDLE,
      default: '0
   };

   dmr_dev_st_t s_q;
   dmr_dev_st_t s_d;
   logic selected;
   logic check_act;
   logic bad;
   logic is_mrs;
   logic wr5;
   logic wr6;
   logic [MR_W-1:0] op;

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      s_d.exec = 1'b0;
      s_d.par_pulse = 1'b0;
      // Command present when selected; clock enable, termination and
      // select take no part in the parity sum
      selected = bus.cke && !bus.cs_n;
      // Checking follows the stored latency, flag and persistent mode
      check_act = check_live(s_q.par_lat, s_q.par_err,
                             s_q.persist);
      // Odd count over covered pins plus parity pin is an error
      bad = selected && check_act
            && (dmr_ca_parity(bus.ca) != bus.par);
      // Set command: strobes low, activate high
      is_mrs = selected && bus.ca.act_n && !bus.ca.ras_n
               && !bus.ca.cas_n && !bus.ca.we_n;
      op = dmr_op_of(bus.ca);
      // Only a command that passed the check may write a register
      wr5 = is_mrs && !bad && (sel_of(op) == SEL_MR5);
      wr6 = is_mrs && !bad && (sel_of(op) == SEL_MR6);

      // A command failing a live parity check is dropped, any other executes
      if (bad) begin
         s_d.par_pulse = 1'b1;
      end else if (selected) begin
         s_d.exec = 1'b1;
         s_d.pins = bus.ca;
      end

      // Fifth register: latency and persistent mode
      if (wr5) begin
         s_d.par_lat = op[MR5_LAT_LSB +: 3];
         s_d.persist = op[MR5_PERSIST_BIT];
      end

      // Error flags: set wins over a clear in the same cycle;
      // writing one leaves a flag as it is, so an error arriving
      // beside its clear is never lost
      s_d.par_err = bad
         || (s_q.par_err && !(wr5 && !op[MR5_PAR_BIT]));
      s_d.crc_err = write_crc_error
         || (s_q.crc_err && !(wr5 && !op[MR5_CRC_BIT]));

      // Sixth register; reserved bits are not stored
      // Reserved rate codes are stored as written and only flagged
      if (wr6) begin
         s_d.rate = op[MR6_RATE_LSB +: 3];
         s_d.cal_en = op[MR6_CAL_EN_BIT];
         // Range and value move only with calibration enabled
         if (op[MR6_CAL_EN_BIT]) begin
            s_d.range = op[MR6_RANGE_BIT];
            s_d.value = op[MR6_VAL_LSB +: 6];
         end
      end

      // Derived status, registered with the fields
      // Monitor output follows the calibration enable directly
      s_d.rate_rsvd = s_d.rate > RATE_TOP;
      s_d.value_bad = s_d.value > VREF_LAST;
      // Taken from the next values so it agrees with the stored fields
      s_d.check_on = check_live(s_d.par_lat, s_d.par_err,
                                s_d.persist);
      s_d.mon_en = s_d.cal_en;
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   // Clock enable low freezes every field, pulses included
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= ST_RESET;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   // Outputs straight from the state register; no logic after flops
   assign cmd_exec = s_q.exec;
   assign cmd_pins = s_q.pins;
   assign parity_error_pulse = s_q.par_pulse;
   assign parity_error_flag = s_q.par_err;
   assign crc_error_flag = s_q.crc_err;
   assign parity_check_on = s_q.check_on;
   assign parity_latency = s_q.par_lat;
   assign persistent_mode = s_q.persist;
   assign data_rate = s_q.rate;
   assign data_rate_reserved = s_q.rate_rsvd;
   assign vref_cal_en = s_q.cal_en;
   assign vref_range = s_q.range;
   assign vref_value = s_q.value;
   assign vref_value_bad = s_q.value_bad;
   assign vref_monitor_en = s_q.mon_en;

endmodule : dmr_device

// >>> dmr_ctrl.sv
// Controller end: issues mode register set commands from software.
// Assumes a simple register port and the device on the same clock.
`timescale 1ns/10ps
module dmr_ctrl #(
   parameter logic [2:0] RATE_CODE = 3'h0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   dmr_if.ctl bus,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   import dmr_pkg::*;

   // ***************************************************************
   // State
   // ***************************************************************
   typedef enum logic [0:0] {CT_IDLE, CT_ISSUE} dmr_ct_state_t;

   typedef struct packed {
      dmr_ct_state_t st;
      logic cs_n;
      dmr_ca_t ca;
      logic par;
      logic inject;
      logic [6:0] vref;
      logic [MR_W-1:0] last;
      logic [31:0] rdata;
   } dmr_ct_st_t;

   localparam dmr_ct_st_t CT_RESET = '{
      st: CT_IDLE, cs_n: 1'b1, ca: CA_IDLE, par: 1'b0, default: '0
   };

   dmr_ct_st_t s_q;
   dmr_ct_st_t s_d;
   logic [MR_W-1:0] op;
   logic go;
   logic [5:0] val;

   // Clean an order: reserved bits zero; sixth register rate forced, enable set if calibration fields change
   function automatic logic [MR_W-1:0] fix_op(input logic [MR_W-1:0] raw,
                                             input logic [6:0] shadow);
      logic [MR_W-1:0] w;
      w = raw;
      w[RSV21_BIT] = 1'b0;
      w[RSV17_BIT] = 1'b0;
      if (w[SEL_LSB +: 3] == SEL_MR6) begin
         w[RSV13_BIT] = 1'b0;
         w[RSV9_BIT] = 1'b0;
         w[RSV8_BIT] = 1'b0;
         w[MR6_RATE_LSB +: 3] = RATE_CODE;
         if (w[MR6_VAL_LSB +: 7] != shadow) begin
            w[MR6_CAL_EN_BIT] = 1'b1;
         end
      end
      fix_op = w;
   endfunction : fix_op

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      s_d.rdata = 32'h00000000;
      op = s_q.last;
      go = 1'b0;
      val = s_q.vref[5:0];
      // Register writes; orders are ignored while a command is out
      if (reg_wr) begin
         case (reg_addr)
            REG_MRS_OP: begin
               op = fix_op(reg_wdata[MR_W-1:0], s_q.vref);
               go = s_q.st == CT_IDLE;
            end
            REG_CTRL: begin
               s_d.inject = reg_wdata[0];
            end
            REG_STEP: begin
               // One step up or down, saturating at the ends
               if (reg_wdata[0] && val < VREF_LAST) begin
                  val = val + 6'h01;
               end else if (reg_wdata[1] && val != 6'h00) begin
                  val = val - 6'h01;
               end
               op = fix_op({1'b0, SEL_MR6, 4'h0, 1'b0, RATE_CODE, 2'h0,
                            1'b1, s_q.vref[6], val}, s_q.vref);
               go = s_q.st == CT_IDLE;
            end
            default: begin
            end
         endcase
      end
      // Register reads, answered one cycle later
      if (reg_rd) begin
         case (reg_addr)
            REG_MRS_OP: s_d.rdata = {10'h000, s_q.last};
            REG_CTRL: s_d.rdata = {31'h00000000, s_q.inject};
            REG_STEP: s_d.rdata = {25'h0000000, s_q.vref};
            REG_STATUS: s_d.rdata = {31'h00000000, s_q.st == CT_ISSUE};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Command sequencer: one cycle of set command, then deselect
      case (s_q.st)
         CT_IDLE: begin
            if (go) begin
               s_d.st = CT_ISSUE;
               s_d.cs_n = 1'b0;
               s_d.ca.act_n = 1'b1;
               s_d.ca.ras_n = 1'b0;
               s_d.ca.cas_n = 1'b0;
               s_d.ca.we_n = 1'b0;
               s_d.ca.bg = op[21:20];
               s_d.ca.ba = op[19:18];
               s_d.ca.a17 = op[17];
               s_d.ca.addr = op[13:0];
               s_d.last = op;
               s_d.inject = 1'b0;
               if (op[SEL_LSB +: 3] == SEL_MR6 && op[MR6_CAL_EN_BIT]) begin
                  s_d.vref = op[MR6_VAL_LSB +: 7];
               end
            end
         end
         CT_ISSUE: begin
            s_d.st = CT_IDLE;
            s_d.cs_n = 1'b1;
            s_d.ca = CA_IDLE;
         end
         default: begin
            s_d.st = CT_IDLE;
         end
      endcase
      // Even parity over covered pins; inject flips it once
      s_d.par = dmr_ca_parity(s_d.ca)
                ^ (s_q.inject && go);
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= CT_RESET;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Bus pins from flops; clock enable high, termination off
   assign bus.cke = 1'b1;
   assign bus.odt = 1'b0;
   assign bus.cs_n = s_q.cs_n;
   assign bus.ca = s_q.ca;
   assign bus.par = s_q.par;
   assign reg_rdata = s_q.rdata;

endmodule : dmr_ctrl

// >>> dmr_assertions.sv
// Checker for the command bus between controller and device.
// Assumes the interface signals are wired in by name, ce held high.
`timescale 1ns/10ps
module dmr_assertions #(
   parameter logic [2:0] RATE_CODE = 3'h0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic odt,
   input wire logic par,
   input wire dmr_pkg::dmr_ca_t ca
);
   import dmr_pkg::*;
   // ***************************************************************
   // Command bus checks
   // ***************************************************************
   logic [6:0] shadow_q;
   logic mr6;
   // Sixth register write on the pins
   assign mr6 = !cs_n && {ca.bg[0], ca.ba} == SEL_MR6;
   // Calibration fields last sent with the enable set
   always_ff @(posedge clock) begin
      if (rst)
         shadow_q <= 7'h00;
      else if (mr6 && ca.addr[7])
         shadow_q <= ca.addr[6:0];
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   a_strobes_low: assert property (
      !cs_n |-> ca.act_n && !(ca.ras_n | ca.cas_n | ca.we_n))
      else $error("Set command without low strobes");
   a_select_one_cycle: assert property (
      !cs_n |=> cs_n)
      else $error("Select held beyond one cycle");
   a_idle_even: assert property (
      cs_n |-> ca == CA_IDLE && !par)
      else $error("Idle pins not at rest");
   a_cke_odt_fixed: assert property (
      cke && !odt)
      else $error("Clock enable or termination moved");
   a_reserved_zero: assert property (
      !cs_n |-> !ca.bg[1] && !ca.a17)
      else $error("Reserved bit 21 or 17 set");
   a_mr6_reserved: assert property (
      mr6 |-> !(ca.addr[13] | ca.addr[9] | ca.addr[8]))
      else $error("Reserved bit 13, 9 or 8 set");
   a_rate_match: assert property (
      mr6 |-> ca.addr[12:10] == RATE_CODE)
      else $error("Data rate does not match clock");
   a_cal_enable: assert property (
      mr6 && ca.addr[6:0] != shadow_q |-> ca.addr[7])
      else $error("Calibration fields changed without enable");
   c_mr5_write: cover property (!cs_n && {ca.bg[0], ca.ba} == SEL_MR5);
   c_mr6_write: cover property (mr6);
   c_bad_parity: cover property (!cs_n && par != ^ca);
endmodule : dmr_assertions

// >>> dram_mode_reg_six_parity_status_test.sv
// Testbench joining controller and device ends over the command bus.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/10ps
module dram_mode_reg_six_parity_status_test;
   import dmr_pkg::*;
   // ***************************************************************
   // Stimulus, model and comparison
   // ***************************************************************
   localparam logic [2:0] RATE = 3'h4;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   logic crc_err = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic rd_seen = 1'h0;
   logic [31:0] reg_rdata;
   logic cmd_exec, pe_pulse, pe_flag, crc_flag, chk_on, persist;
   logic rate_rsv, cal_en, rng, val_bad, mon_en;
   logic [2:0] lat, rate;
   logic [5:0] val;
   dmr_ca_t pins;
   logic [22:0] got;
   logic m_pe = 1'h0, m_crc = 1'h0, m_pers = 1'h0, m_cal = 1'h0;
   logic m_rng = 1'h0;
   logic [2:0] m_lat = 3'h0, m_rate = 3'h0;
   logic [5:0] m_val = 6'h00;
   logic [21:0] m_op = 22'h0;
   logic [22:0] exp_q[$];
   logic [31:0] rd_q[$];
   dmr_ca_t pins_q[$];
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   dmr_if dmr_if_inst ();
   // Both ends and the checker on one bus
   dmr_ctrl #(.RATE_CODE(RATE)) dmr_ctrl_inst (.clock(clock), .rst(rst),
      .ce(ce), .bus(dmr_if_inst.ctl), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   dmr_device dmr_device_inst (.clock(clock), .rst(rst), .ce(ce),
      .bus(dmr_if_inst.dev), .write_crc_error(crc_err),
      .cmd_exec(cmd_exec), .cmd_pins(pins), .parity_error_pulse(pe_pulse),
      .parity_error_flag(pe_flag), .crc_error_flag(crc_flag),
      .parity_check_on(chk_on), .parity_latency(lat),
      .persistent_mode(persist), .data_rate(rate),
      .data_rate_reserved(rate_rsv), .vref_cal_en(cal_en),
      .vref_range(rng), .vref_value(val), .vref_value_bad(val_bad),
      .vref_monitor_en(mon_en));
   dmr_assertions #(.RATE_CODE(RATE)) dmr_assertions_inst (.clock(clock),
      .rst(rst), .cke(dmr_if_inst.cke), .cs_n(dmr_if_inst.cs_n),
      .odt(dmr_if_inst.odt), .par(dmr_if_inst.par), .ca(dmr_if_inst.ca));
   // Device outputs gathered for comparison
   assign got = {cmd_exec, pe_pulse, pe_flag, crc_flag, chk_on, lat,
                 persist, rate, rate_rsv, cal_en, rng, val, val_bad, mon_en};
   always #5 clock = ~clock;

   function automatic logic on_f();
      on_f = m_lat != 3'h0 && m_lat <= LAT_MAX && (!m_pe || m_pers);
   endfunction : on_f

   function automatic logic [22:0] snap(input logic ex, input logic pe);
      snap = {ex, pe, m_pe, m_crc, on_f(), m_lat, m_pers, m_rate,
              m_rate > RATE_TOP, m_cal, m_rng, m_val, m_val > VREF_LAST,
              m_cal};
   endfunction : snap

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic results();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // One register port cycle; strobes fall when the next call lands
   task automatic bus(input logic w, input logic r, input logic [3:0] a,
                      input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'h0, 1'h1, a, 32'h0);
   endtask : rd

   // Model the device for one command and note the expected report
   task automatic apply(input logic [21:0] c, input logic bad);
      if (bad && on_f()) begin
         m_pe = 1'h1;
         exp_q.push_back(snap(1'h0, 1'h1));
      end else begin
         if (c[20:18] == SEL_MR5) begin
            m_lat = c[2:0];
            m_pers = c[MR5_PERSIST_BIT];
            m_pe = m_pe & c[MR5_PAR_BIT];
            m_crc = m_crc & c[MR5_CRC_BIT];
         end
         if (c[20:18] == SEL_MR6) begin
            m_rate = c[12:10];
            m_cal = c[MR6_CAL_EN_BIT];
            if (m_cal) begin
               m_rng = c[MR6_RANGE_BIT];
               m_val = c[5:0];
            end
         end
         // Pin image of the command through the mode word mapping
         pins_q.push_back('{1'h1, 1'h0, 1'h0, 1'h0, c[17], c[21:20],
                            c[19:18], c[13:0]});
         exp_q.push_back(snap(1'h1, 1'h0));
      end
      bus(1'h0, 1'h0, 4'h0, 32'h0);
      repeat (2) @(posedge clock);
   endtask : apply

   task automatic issue(input logic [21:0] op, input logic inj);
      logic [21:0] c;
      c = op;
      c[21] = 1'h0;
      c[17] = 1'h0;
      if (c[20:18] == SEL_MR6) begin
         c[13] = 1'h0;
         c[9] = 1'h0;
         c[8] = 1'h0;
         c[12:10] = RATE;
         if (c[6:0] != {m_rng, m_val})
            c[7] = 1'h1;
      end
      if (inj)
         bus(1'h1, 1'h0, REG_CTRL, 32'h1);
      bus(1'h1, 1'h0, REG_MRS_OP, {10'h0, op});
      m_op = c;
      apply(c, inj);
   endtask : issue

   task automatic step(input logic [1:0] dir);
      if (dir[0])
         m_val = (m_val == VREF_LAST) ? m_val : m_val + 6'h1;
      else if (m_val != 6'h00)
         m_val = m_val - 6'h1;
      bus(1'h1, 1'h0, REG_STEP, {30'h0, dir});
      apply({1'h0, SEL_MR6, 5'h00, RATE, 3'h1, m_rng, m_val}, 1'h0);
   endtask : step

   // Takes the oldest note whenever a report or read data appear
   always @(posedge clock) begin
      if ((cmd_exec | pe_pulse) === 1'h1)
         chk(32'(got), 32'(exp_q.pop_front()));
      if (cmd_exec === 1'h1)
         chk(32'(pins), 32'(pins_q.pop_front()));
      if (rd_seen)
         chk(reg_rdata, rd_q.pop_front());
      rd_seen <= reg_rd;
   end

   // Cuts a hung run short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         results();
      end
   end

   // Main sequence
   initial begin
      void'($urandom(49));
      repeat (16) @(posedge clock);
      rst <= 1'h0;
      @(posedge clock);
      chk(32'(got), 32'(snap(1'h0, 1'h0)));
      rd(REG_STEP, 32'h0);
      rd(4'h2, 32'h0);
      issue({1'h0, 3'h0, 18'h00ABC}, 1'h1);
      crc_err <= 1'h1;
      @(posedge clock);
      crc_err <= 1'h0;
      m_crc = 1'h1;
      issue({1'h0, 3'h3, 18'h00001}, 1'h0);
      issue({1'h0, SEL_MR5, 18'h00008}, 1'h0);
      for (int k = 0; k < 8; k++) begin
         issue({1'h0, SEL_MR5, 15'h0, 3'(k)}, 1'h0);
         issue({1'h0, 3'h2, 18'h3FFFF}, 1'h1);
         issue({1'h0, 3'h2, 18'h00000}, 1'h1);
         issue({1'h0, SEL_MR5, 18'h00000}, 1'h0);
      end
      issue({1'h0, SEL_MR5, 18'h00201}, 1'h0);
      issue({1'h0, 3'h1, 18'h01234}, 1'h1);
      issue({1'h0, 3'h1, 18'h01235}, 1'h1);
      issue({1'h0, SEL_MR5, 18'h00000}, 1'h0);
      issue({1'h1, SEL_MR6, 18'h3FF71}, 1'h0);
      step(2'h1);
      step(2'h2);
      step(2'h3);
      issue({1'h0, SEL_MR6, 18'h00080}, 1'h0);
      step(2'h2);
      rd(REG_STEP, {25'h0, m_rng, m_val});
      issue({1'h0, SEL_MR6, 18'h00000}, 1'h0);
      issue({1'h0, SEL_MR6, 18'h000B2}, 1'h0);
      issue({1'h0, SEL_MR5, 18'h00002}, 1'h0);
      // A CRC pulse while frozen must leave the cleared flag alone
      ce <= 1'h0;
      crc_err <= 1'h1;
      repeat (2) @(posedge clock);
      ce <= 1'h1;
      crc_err <= 1'h0;
      @(posedge clock);
      chk(32'(crc_flag), 32'(m_crc));
      for (int i = 0; i < 30; i++) begin
         logic [21:0] op;
         op = 22'($urandom);
         issue(op, op[20:18] != SEL_MR6 && $urandom % 4 == 0);
      end
      rd(REG_MRS_OP, {10'h0, m_op});
      bus(1'h0, 1'h0, 4'h0, 32'h0);
      repeat (3) @(posedge clock);
      chk(32'(exp_q.size() + pins_q.size() + rd_q.size()), 32'h0);
      results();
   end
endmodule : dram_mode_reg_six_parity_status_test
